// ---- verilog/idp_pkg.sv ----
// idp_pkg: constants and types of the two-wire display RAM port
package idp_pkg;
   // ======================================================
   // slave address and control byte
   localparam logic [4:0] IDP_SLAVE_BASE = 5'h0F;  // upper five bits 01111
   localparam int         IDP_CTL_CONT   = 7;      // continuation_flag
   localparam int         IDP_CTL_DCS    = 6;      // data_command_select
   localparam logic [3:0] IDP_BIT_LAST   = 4'h8;   // bits in a byte
   // ======================================================
   // address ranges
   localparam logic [7:0] IDP_COL_LAST   = 8'h65;  // column 101
   localparam logic [3:0] IDP_PAGE_LAST  = 4'h9;   // page 9
   localparam logic [3:0] IDP_ICON_PAGE  = 4'h9;   // icon page
   localparam logic [7:0] IDP_ICON_MASK  = 8'h01;  // only bit 0 is kept
   localparam logic [6:0] IDP_COM_LAST   = 7'h42;  // com66
   // ======================================================
   // instruction opcodes (upper nibble, bit 7 low)
   localparam logic [3:0] IDP_OP_COL_LO  = 4'h0;
   localparam logic [3:0] IDP_OP_COL_HI  = 4'h1;
   localparam logic [3:0] IDP_OP_PAGE    = 4'h2;
   localparam logic [3:0] IDP_OP_MIRROR  = 4'h3;
   localparam int         IDP_MIR_COL    = 0;      // column_mirror bit
   localparam int         IDP_MIR_ROW    = 1;      // row_mirror bit
   localparam int         IDP_OP_LINE    = 7;      // set: start-line load
   localparam int         IDP_FIFO_DEPTH = 8;
   // ======================================================
   // types
   typedef struct packed {
      logic [3:0] page;
      logic [7:0] col;
   } idp_ptr_t;
   typedef struct packed {
      idp_ptr_t   ptr;
      logic [7:0] data;
   } idp_ram_wr_t;
   typedef enum {IDP_ST_IDLE, IDP_ST_RX, IDP_ST_ACK, IDP_ST_TX,
                 IDP_ST_MACK} idp_state_t;
   typedef enum {IDP_PH_ADDR, IDP_PH_CTRL, IDP_PH_DATA} idp_phase_t;
endpackage : idp_pkg

// ---- verilog/idp_port.sv ----
// idp_port: two-wire slave port, pointer logic and display scan counters
`timescale 1ns/100ps

// ======================================================
// fifo: flip-flop storage indexed by read and write pointers
module idp_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];   // storage words
   logic [AW:0]      wp_reg, wp_next;   // write pointer with wrap bit
   logic [AW:0]      rp_reg, rp_next;   // read pointer with wrap bit
   logic             push, pop;

   // full when pointers differ only in the wrap bit
   always_comb begin
      in_ready  = (wp_reg[AW] == rp_reg[AW])
               || (wp_reg[AW-1:0] != rp_reg[AW-1:0]);
      out_valid = (wp_reg != rp_reg);
      out_data  = mem_reg[rp_reg[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_next   = push ? wp_reg + 1'b1 : wp_reg;
      rp_next   = pop ? rp_reg + 1'b1 : rp_reg;
   end

   // pointers and storage registered under the clock enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else if (clk_en) begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         if (push) begin
            mem_reg[wp_reg[AW-1:0]] <= in_data;
         end
      end
   end
endmodule : idp_fifo

// ======================================================
// port top
module idp_port
   import idp_pkg::*;
(
   // clock, enable, reset
   input  wire logic        mclk,
   input  wire logic        clk_en,
   input  wire logic        rst_b,
   // two-wire bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // static address straps
   input  wire logic        addr_select_pin_low,
   input  wire logic        addr_select_pin_high,
   // display RAM write stream
   output logic             ram_wr_valid,
   input  wire logic        ram_wr_ready,
   output idp_pkg::idp_ram_wr_t ram_wr,
   // display RAM read port, combinational data back
   output idp_pkg::idp_ptr_t ram_rd_ptr,
   input  wire logic [7:0]  ram_rd_data,
   // configuration state
   output logic             column_mirror,
   output logic             row_mirror,
   output logic [6:0]       start_line,
   // display scan timing
   input  wire logic        frame_start,
   input  wire logic        line_step_clock,
   input  wire logic [7:0]  scan_seg,
   output logic [6:0]       disp_line,
   output logic [6:0]       disp_com,
   output logic [7:0]       disp_col
);
   import idp_pkg::*;

   // ======================================================
   // reset release and pin synchronisers
   logic rst_s1_reg, rst_s2_reg;          // reset release chain
   logic scl_s1_reg, scl_s2_reg, scl_d_reg; // scl sync and delay
   logic sda_s1_reg, sda_s2_reg, sda_d_reg; // sda sync and delay
   logic [1:0] sel_s1_reg, sel_s2_reg;      // address strap sync
   logic rst_n;

   // reset enters asynchronously, leaves through two flops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_n = rst_s2_reg;

   // idle bus is high, so the scl and sda chains reset high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
         sel_s1_reg <= '0;
         sel_s2_reg <= '0;
      end else if (clk_en) begin
         // straps are pins too, so they pass two flops as well
         sel_s1_reg <= {addr_select_pin_high, addr_select_pin_low};
         sel_s2_reg <= sel_s1_reg;
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   // edges seen only on the second flop and its delayed copy
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise   = scl_s2_reg && !scl_d_reg;
   assign scl_fall   = !scl_s2_reg && scl_d_reg;
   assign start_cond = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
   assign stop_cond  = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;

   // ======================================================
   // protocol engine
   idp_state_t  st_reg, st_next;          // bus state
   idp_phase_t  ph_reg, ph_next;          // which byte is expected
   logic [7:0]  sh_reg, sh_next;          // shift register
   logic [3:0]  bc_reg, bc_next;          // bit count
   logic        oe_reg, oe_next;          // SDA pull-down
   logic        txa_reg, txa_next;        // send after the ack
   logic        cont_reg, cont_next;      // continuation_flag latched
   logic        dcs_reg, dcs_next;        // data_command_select latched
   logic        mack_reg, mack_next;      // master acknowledged
   logic [7:0]  hold_reg, hold_next;      // bus holder for reads
   idp_ptr_t    ptr_reg, ptr_next;        // page and column pointer
   logic        cmir_reg, cmir_next;      // column_mirror
   logic        rmir_reg, rmir_next;      // row_mirror
   logic [6:0]  sl_reg, sl_next;          // start line register
   idp_ram_wr_t wr_word;
   logic        wr_push, wr_ready;
   logic [6:0]  own_addr;

   assign own_addr = {IDP_SLAVE_BASE, sel_s2_reg};

   // next pointer: column wraps at 101, page at 9
   function automatic idp_ptr_t ptr_step(input idp_ptr_t p);
      idp_ptr_t n;
      n = p;
      if (p.col >= IDP_COL_LAST) begin
         n.col  = '0;
         n.page = (p.page >= IDP_PAGE_LAST) ? 4'h0 : p.page + 4'h1;
      end else begin
         n.col = p.col + 8'h01;
      end
      return n;
   endfunction : ptr_step

   // one bit shifted in or out per SCL period
   always_comb begin
      st_next   = st_reg;
      ph_next   = ph_reg;
      sh_next   = sh_reg;
      bc_next   = bc_reg;
      oe_next   = oe_reg;
      txa_next  = txa_reg;
      cont_next = cont_reg;
      dcs_next  = dcs_reg;
      mack_next = mack_reg;
      hold_next = hold_reg;
      ptr_next  = ptr_reg;
      cmir_next = cmir_reg;
      rmir_next = rmir_reg;
      sl_next   = sl_reg;
      wr_push   = 1'b0;
      wr_word   = '{ptr: ptr_reg, data: sh_reg};
      if (ptr_reg.page == IDP_ICON_PAGE) begin
         wr_word.data = sh_reg & IDP_ICON_MASK;
      end
      if (start_cond) begin
         // repeated START also lands here and restarts parsing
         st_next = IDP_ST_RX;
         ph_next = IDP_PH_ADDR;
         bc_next = '0;
         oe_next = 1'b0;
      end else if (stop_cond) begin
         st_next = IDP_ST_IDLE;
         oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            IDP_ST_IDLE: begin
               oe_next = 1'b0;                         // not addressed
            end
            IDP_ST_RX: begin
               if (scl_rise && bc_reg < IDP_BIT_LAST) begin
                  sh_next = {sh_reg[6:0], sda_s2_reg};
                  bc_next = bc_reg + 4'h1;
               end else if (scl_fall && bc_reg == IDP_BIT_LAST) begin
                  st_next  = IDP_ST_ACK;
                  oe_next  = 1'b1;
                  txa_next = 1'b0;
                  unique case (ph_reg)
                     IDP_PH_ADDR: begin
                        if (sh_reg[7:1] != own_addr) begin
                           st_next = IDP_ST_IDLE;
                           oe_next = 1'b0;
                        end else if (sh_reg[0]) begin
                           // reads only while data_command_select is clear, as after reset or an instruction write
                           txa_next = !dcs_reg;
                           oe_next  = !dcs_reg;
                           st_next  = dcs_reg ? IDP_ST_IDLE : IDP_ST_ACK;
                        end else begin
                           ph_next = IDP_PH_CTRL;
                        end
                     end
                     IDP_PH_CTRL: begin
                        cont_next = sh_reg[IDP_CTL_CONT];
                        dcs_next  = sh_reg[IDP_CTL_DCS];
                        ph_next   = IDP_PH_DATA;
                     end
                     IDP_PH_DATA: begin
                        // back to control only while continuation set
                        ph_next = cont_reg ? IDP_PH_CTRL
                                           : IDP_PH_DATA;
                        if (dcs_reg) begin
                           wr_push = 1'b1;
                           if (wr_ready) begin
                              ptr_next = ptr_step(ptr_reg);
                           end else begin
                              // full buffer: refuse the byte with no ack
                              oe_next = 1'b0;
                              st_next = IDP_ST_IDLE;
                           end
                        end else if (sh_reg[IDP_OP_LINE]) begin
                           sl_next = sh_reg[6:0];
                        end else begin
                           unique case (sh_reg[7:4])
                              IDP_OP_COL_LO: ptr_next.col[3:0] = sh_reg[3:0];
                              IDP_OP_COL_HI: ptr_next.col[7:4] = sh_reg[3:0];
                              IDP_OP_PAGE: begin
                                 ptr_next.page = sh_reg[3:0];
                              end
                              IDP_OP_MIRROR: begin
                                 cmir_next = sh_reg[IDP_MIR_COL];
                                 rmir_next = sh_reg[IDP_MIR_ROW];
                              end
                              default: ;               // unknown opcode
                           endcase
                        end
                     end
                  endcase
               end
            end
            IDP_ST_ACK: begin
               if (scl_fall) begin
                  oe_next = 1'b0;                      // ack slot over
                  bc_next = '0;
                  st_next = IDP_ST_RX;
                  if (txa_reg) begin
                     // holder gives stale byte, then reloads: dummy read
                     sh_next   = hold_reg;
                     hold_next = ram_rd_data;
                     ptr_next  = ptr_step(ptr_reg);
                     oe_next   = !hold_reg[7];
                     st_next   = IDP_ST_TX;
                  end
               end
            end
            IDP_ST_TX: begin
               if (scl_fall) begin
                  bc_next = bc_reg + 4'h1;
                  sh_next = {sh_reg[6:0], 1'b1};
                  oe_next = !sh_reg[6];
                  if (bc_reg == IDP_BIT_LAST - 4'h1) begin
                     oe_next = 1'b0;                   // free SDA for ack
                     st_next = IDP_ST_MACK;
                  end
               end
            end
            IDP_ST_MACK: begin
               if (scl_rise) begin
                  mack_next = !sda_s2_reg;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     bc_next   = '0;
                     sh_next   = hold_reg;
                     hold_next = ram_rd_data;
                     ptr_next  = ptr_step(ptr_reg);
                     oe_next   = !hold_reg[7];
                     st_next   = IDP_ST_TX;
                  end else begin
                     oe_next = 1'b0;
                     st_next = IDP_ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // protocol state registered under the clock enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg   <= IDP_ST_IDLE;
         ph_reg   <= IDP_PH_ADDR;
         sh_reg   <= '0;
         bc_reg   <= '0;
         oe_reg   <= 1'b0;
         txa_reg  <= 1'b0;
         cont_reg <= 1'b0;
         dcs_reg  <= 1'b0;
         mack_reg <= 1'b0;
         hold_reg <= '0;
         ptr_reg  <= '0;
         cmir_reg <= 1'b0;
         rmir_reg <= 1'b0;
         sl_reg   <= '0;
      end else if (clk_en) begin
         st_reg   <= st_next;
         ph_reg   <= ph_next;
         sh_reg   <= sh_next;
         bc_reg   <= bc_next;
         oe_reg   <= oe_next;
         txa_reg  <= txa_next;
         cont_reg <= cont_next;
         dcs_reg  <= dcs_next;
         mack_reg <= mack_next;
         hold_reg <= hold_next;
         ptr_reg  <= ptr_next;
         cmir_reg <= cmir_next;
         rmir_reg <= rmir_next;
         sl_reg   <= sl_next;
      end
   end

   // open drain: only ever pull low
   assign sda_out       = 1'b0;
   assign sda_oe        = oe_reg;
   assign ram_rd_ptr    = ptr_reg;
   assign column_mirror = cmir_reg;
   assign row_mirror    = rmir_reg;
   assign start_line    = sl_reg;

   // write buffer lets the RAM side stall without losing bytes
   idp_fifo #(
      .WIDTH ($bits(idp_ram_wr_t)),
      .DEPTH (IDP_FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .in_valid  (wr_push),
      .in_ready  (wr_ready),
      .in_data   (wr_word),
      .out_valid (ram_wr_valid),
      .out_ready (ram_wr_ready),
      .out_data  (ram_wr)
   );

   // ======================================================
   // display scan counters
   logic [6:0] ln_reg, ln_next;           // RAM line for current com
   logic [6:0] cc_reg, cc_next;           // com scan position
   logic [6:0] dcom_reg, dcom_next;       // mirrored com output
   logic [7:0] dcol_reg, dcol_next;       // mirrored column

   // counters cover rows 0..66 only, so icon row 67 never scrolls
   always_comb begin
      ln_next = ln_reg;
      cc_next = cc_reg;
      if (frame_start) begin
         ln_next = sl_reg;
         cc_next = '0;
      end else if (line_step_clock) begin
         ln_next = (ln_reg >= IDP_COM_LAST) ? 7'h00 : ln_reg + 7'h01;
         cc_next = (cc_reg >= IDP_COM_LAST) ? 7'h00 : cc_reg + 7'h01;
      end
      dcom_next = rmir_reg ? IDP_COM_LAST - cc_reg : cc_reg;
      dcol_next = cmir_reg ? IDP_COL_LAST - scan_seg : scan_seg;
   end

   // scan state registered under the clock enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ln_reg   <= '0;
         cc_reg   <= '0;
         dcom_reg <= '0;
         dcol_reg <= '0;
      end else if (clk_en) begin
         ln_reg   <= ln_next;
         cc_reg   <= cc_next;
         dcom_reg <= dcom_next;
         dcol_reg <= dcol_next;
      end
   end

   assign disp_line = ln_reg;
   assign disp_com  = dcom_reg;
   assign disp_col  = dcol_reg;
endmodule : idp_port

// ---- test/idp_port_monitor.sv ----
// idp_port_monitor: concurrent checks on the port pins
`timescale 1ns/100ps
module idp_port_monitor
   import idp_pkg::*;
(
   // clock and reset
   input wire logic                  mclk,
   input wire logic                  rst_b,
   // bus side
   input wire logic                  scl_in,
   input wire logic                  sda_oe,
   // display RAM stream
   input wire logic                  ram_wr_valid,
   input wire logic                  ram_wr_ready,
   input wire idp_pkg::idp_ram_wr_t  ram_wr,
   // configuration and scan
   input wire logic                  column_mirror,
   input wire logic [6:0]            start_line,
   input wire logic                  frame_start,
   input wire logic                  line_step_clock,
   input wire logic [7:0]            scan_seg,
   input wire logic [6:0]            disp_line,
   input wire logic [7:0]            disp_col
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ======================================================
   // bus pin
   property p_oe_still;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_oe_still: assert property (p_oe_still)
      else $error("data pull moved while clock high");
   // an ack or low bit lasts a whole slot, never a glitch
   property p_oe_stand;
      $rose(sda_oe) |-> sda_oe [*6];
   endproperty
   a_oe_stand: assert property (p_oe_stand)
      else $error("data pull released too early");
   // ======================================================
   // RAM stream
   property p_wr_hold;
      ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("stalled RAM word changed");
   property p_icon;
      ram_wr_valid && ram_wr.ptr.page == IDP_ICON_PAGE
         |-> (ram_wr.data & ~IDP_ICON_MASK) == 8'h00;
   endproperty
   a_icon: assert property (p_icon)
      else $error("icon word carries upper bits");
   property p_range;
      ram_wr_valid |-> ram_wr.ptr.col <= IDP_COL_LAST
         && ram_wr.ptr.page <= IDP_PAGE_LAST;
   endproperty
   a_range: assert property (p_range)
      else $error("RAM pointer out of range");
   // ======================================================
   // scan counters, column check held off until internal reset is over
   property p_disp_col;
      $past(rst_b, 4) |=> disp_col == ($past(column_mirror) ?
         IDP_COL_LAST - $past(scan_seg) : $past(scan_seg));
   endproperty
   a_disp_col: assert property (p_disp_col)
      else $error("segment order wrong");
   property p_line_load;
      frame_start |=> disp_line == $past(start_line);
   endproperty
   a_line_load: assert property (p_line_load)
      else $error("line counter not loaded at frame start");
   property p_line_step;
      line_step_clock && !frame_start |=> disp_line ==
         ($past(disp_line) == IDP_COM_LAST ? 7'h00 : $past(disp_line) + 7'h01);
   endproperty
   a_line_step: assert property (p_line_step)
      else $error("line counter step wrong");
endmodule : idp_port_monitor

// ---- test/idp_master.sv ----
// idp_master: behavioural two-wire bus master
`timescale 1ns/100ps
module idp_master (
   // bus lines, sda_m high releases the line
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda
);
   // clock stands still high between frames
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // one 320 ns bit slot, line read mid-high
   task automatic bit_slot(input logic b, output logic s);
      #80 sda_m = b;
      #80 scl = 1'b1;
      #80 s = sda;
      #80 scl = 1'b0;
   endtask : bit_slot
   // start or repeated start; offset keeps us off mclk edges
   task automatic start;
      #7;
      #80 sda_m = 1'b1;
      #80 scl = 1'b1;
      #80 sda_m = 1'b0;
      #80 scl = 1'b0;
   endtask : start
   task automatic stop;
      #80 sda_m = 1'b0;
      #80 scl = 1'b1;
      #80 sda_m = 1'b1;
      #80;
   endtask : stop
   // byte then ack slot; ak high leaves the slot to the slave
   task automatic xfer(input logic [7:0] d, input logic ak,
                       output logic [7:0] q, output logic seen);
      for (int i = 7; i >= 0; i--) bit_slot(d[i], q[i]);
      bit_slot(ak, seen);
   endtask : xfer
endmodule : idp_master

// ---- test/tb_top.sv ----
// tb_top: self-checking bench of the two-wire display RAM port
`timescale 1ns/100ps
module tb_top;
   import idp_pkg::*;
   // ======================================================
   // signals
   logic        mclk, rst_b, scl, sda_m, sda, sda_out, sda_oe;
   logic        al, ah, rdy, wv, fs, ls, cm, rm, a;
   logic [7:0]  seg, rd, dcol, r;
   logic [6:0]  sl, dl, dc;
   idp_ram_wr_t wd;
   idp_ptr_t    rp;
   logic [7:0]  mem [0:9][0:101]; // display RAM model
   idp_ram_wr_t got_q[$];          // words taken off the stream
   int          fail_count, checks, cyc;
   // open-drain wire with pull-up
   assign sda = sda_m & ~(sda_oe & ~sda_out);
   assign rd  = mem[rp.page][rp.col];
   idp_port i_idp_port (.mclk(mclk), .clk_en(1'b1), .rst_b(rst_b),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin_low(al), .addr_select_pin_high(ah),
      .ram_wr_valid(wv), .ram_wr_ready(rdy), .ram_wr(wd),
      .ram_rd_ptr(rp), .ram_rd_data(rd), .column_mirror(cm),
      .row_mirror(rm), .start_line(sl), .frame_start(fs),
      .line_step_clock(ls), .scan_seg(seg), .disp_line(dl),
      .disp_com(dc), .disp_col(dcol));
   idp_master i_idp_master (.scl(scl), .sda_m(sda_m), .sda(sda));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // stream sink and hang guard
   always @(posedge mclk) begin
      cyc++;
      if (wv && rdy) begin
         got_q.push_back(wd);
         mem[wd.ptr.page][wd.ptr.col] = wd.data;
      end
      if (cyc == 20000) begin
         fail_count++;
         finish_test;
      end
   end
   // ======================================================
   // shared tasks
   task automatic finish_test;
      if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [19:0] g, input logic [19:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // write one byte, e is the expected ack bit (0 = taken)
   task automatic wb(input logic [7:0] d, input logic e);
      i_idp_master.xfer(d, 1'b1, r, a);
      chk(20'(a), 20'(e));
   endtask : wb
   task automatic sa(input logic rw, input logic e);
      i_idp_master.start;
      wb({IDP_SLAVE_BASE, ah, al, rw}, e);
   endtask : sa
   // ======================================================
   // scenarios
   task automatic t_addr;
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk) {ah, al} <= k[1:0];
         repeat (2) @(posedge mclk);
         i_idp_master.start;
         wb({IDP_SLAVE_BASE, ~k[1:0], 1'b0}, 1'b1);
         wb(8'h00, 1'b1);
         i_idp_master.stop;
         sa(1'b0, 1'b0);
         i_idp_master.stop;
      end
   endtask : t_addr
   task automatic t_cmd;
      sa(1'b0, 1'b0);
      wb(8'h80, 1'b0);
      wb(8'h33, 1'b0);
      wb(8'h00, 1'b0);
      wb(8'hC0, 1'b0);
      wb(8'h16, 1'b0);
      wb(8'h05, 1'b0);
      wb(8'h29, 1'b0);
      i_idp_master.stop;
      chk({cm, rm, sl}, {2'b11, 7'h40});
      @(posedge mclk) begin seg <= 8'h05; fs <= 1'b1; end
      @(posedge mclk) begin fs <= 1'b0; ls <= 1'b1; end
      @(posedge mclk) ls <= 1'b0;
      @(posedge mclk) #1;
      chk(dcol, 8'h60);
      chk(dl, 7'h41);
      chk(dc, 7'h41);
   endtask : t_cmd
   task automatic t_data;
      sa(1'b0, 1'b0);
      wb(8'h40, 1'b0);
      wb(8'hA5, 1'b0);
      wb(8'h3C, 1'b0);
      wb(8'h7E, 1'b0);
      i_idp_master.stop;
      chk(got_q.pop_front(), {4'h9, 8'h65, 8'h01});
      chk(got_q.pop_front(), {4'h0, 8'h00, 8'h3C});
      chk(got_q.pop_front(), {4'h0, 8'h01, 8'h7E});
      sa(1'b1, 1'b1);
      i_idp_master.stop;
   endtask : t_data
   // fill the buffer while the RAM stalls, then drain
   task automatic t_full;
      @(posedge mclk) rdy <= 1'b0;
      sa(1'b0, 1'b0);
      wb(8'h40, 1'b0);
      for (int i = 0; i < 8; i++) wb(8'(i), 1'b0);
      wb(8'hEE, 1'b1);
      i_idp_master.stop;
      @(posedge mclk) rdy <= 1'b1;
      repeat (12) @(posedge mclk);
      for (int i = 0; i < 8; i++)
         chk(got_q.pop_front(), {4'h0, 8'(i + 2), 8'(i)});
      chk(20'(wv), 20'h0);
   endtask : t_full
   task automatic t_read;
      mem[2][10] = 8'h5A;
      mem[2][11] = 8'hC3;
      sa(1'b0, 1'b0);
      wb(8'h00, 1'b0);
      wb(8'h10, 1'b0);
      wb(8'h0A, 1'b0);
      wb(8'h22, 1'b0);
      i_idp_master.stop;
      sa(1'b1, 1'b0);
      i_idp_master.xfer(8'hFF, 1'b0, r, a);
      i_idp_master.xfer(8'hFF, 1'b0, r, a);
      chk(r, 8'h5A);
      i_idp_master.xfer(8'hFF, 1'b1, r, a);
      chk(r, 8'hC3);
      chk(rp, {4'h2, 8'h0D});
      repeat (6) @(posedge mclk);
      chk(sda_oe, 1'b0);
      i_idp_master.stop;
   endtask : t_read
   task automatic t_rstart;
      sa(1'b0, 1'b0);
      wb(8'h40, 1'b0);
      wb(8'h11, 1'b0);
      sa(1'b0, 1'b0);
      wb(8'h00, 1'b0);
      wb(8'h30, 1'b0);
      i_idp_master.stop;
      chk({cm, rm}, 2'b00);
      got_q.delete();
   endtask : t_rstart
   // ======================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      {al, ah, fs, ls} = 4'h0;
      rdy = 1'b1;
      seg = 8'h00;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (6) @(posedge mclk);
      t_addr;
      t_cmd;
      t_data;
      t_full;
      t_read;
      t_rstart;
      finish_test;
   end
endmodule : tb_top
bind idp_port idp_port_monitor i_idp_port_monitor (.mclk(mclk),
   .rst_b(rst_b), .scl_in(scl_in), .sda_oe(sda_oe),
   .ram_wr_valid(ram_wr_valid), .ram_wr_ready(ram_wr_ready),
   .ram_wr(ram_wr), .column_mirror(column_mirror),
   .start_line(start_line), .frame_start(frame_start),
   .line_step_clock(line_step_clock), .scan_seg(scan_seg),
   .disp_line(disp_line), .disp_col(disp_col));
